//--- t2mc_mode_control.sv
// Mode control register of the second timer: baud source, pin role and count direction.
//
// What this block does
// - Receive select bit 5 set: second timer overflow clocks the serial receive side.
// - Transmit select bit 4 set: second timer overflow clocks transmit; clear: first timer.
// - Output enable bit 1 clear: timer pin is an input clocking counter mode.
// - Output enable set: drive timer pin, inverting it on every second timer overflow.
// - Down-count enable bit 0 clear: auto-reload counting runs upward only.
// - Down-count enable set: auto-reload direction comes from the direction pin.
// - Direction pin high counts up, low counts down; the outside drives it.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`include "t2mc_regs.svh"
module t2mc_mode_control (
  input  wire logic                     clk,             // System clock, 50 MHz.
  input  wire logic                     resetn,          // Asynchronous reset, active low.
  input  wire logic [`T2MC_ADDR_W-1:0]  regAddr,         // Register address.
  input  wire logic [7:0]               regWrData,       // Register write data.
  input  wire logic                     regWr,           // Write strobe, one cycle.
  input  wire logic                     regRd,           // Read strobe, one cycle.
  output logic      [7:0]               regRdData,       // Read data, cycle after strobe.
  input  wire logic                     timer1Overflow,  // First timer overflow pulse.
  input  wire logic                     timer2Overflow,  // Second timer overflow pulse.
  input  wire logic                     counterMode,     // Second timer counts pin events.
  input  wire logic                     autoReloadMode,  // Second timer in auto-reload mode.
  input  wire logic                     timerPinIn,      // Timer pin level, asynchronous.
  input  wire logic                     countDirPinIn,   // Direction pin level, asynchronous.
  output logic                          timerPinOut,     // Level driven on the timer pin.
  output logic                          timerPinOe_n,    // Low while the timer pin is driven.
  output logic                          rxBaudTick,      // Receive baud clock pulse.
  output logic                          txBaudTick,      // Transmit baud clock pulse.
  output logic                          counterTick,     // Count pulse from a pin fall.
  output logic                          countUp          // High counts up, low counts down.
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]                  timer2ModeReg_reg;
  logic [7:0]                  timer2ModeReg_next;
  logic [7:0]                  regRdData_reg;
  logic [7:0]                  regRdData_next;
  t2mc_pkg::t2mc_pin_role_t    pinRole_reg;
  t2mc_pkg::t2mc_pin_role_t    pinRole_next;
  logic                        timerPinOut_reg;
  logic                        timerPinOut_next;
  logic                        timerPinOe_n_reg;
  logic                        timerPinOe_n_next;
  logic                        rxBaudTick_reg;
  logic                        rxBaudTick_next;
  logic                        txBaudTick_reg;
  logic                        txBaudTick_next;
  logic                        counterTick_reg;
  logic                        counterTick_next;
  logic                        pinLast_reg;
  logic                        pinLast_next;
  t2mc_pkg::t2mc_dir_t         countDir_reg;
  t2mc_pkg::t2mc_dir_t         countDir_next;
  logic                        timerPinSync;
  logic                        countDirSync;
  logic                        modeHit;
  logic                        serialRxClockSelect;
  logic                        serialTxClockSelect;
  logic                        timerPinOutputEnable;
  logic                        downCountEnable;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  t2mc_sync #(
    .RESET_LEVEL (1'b1)
  ) timerPinSyncInst (
    .clk     (clk),
    .resetn  (resetn),
    .asyncIn (timerPinIn),
    .syncOut (timerPinSync)
  );

  t2mc_sync #(
    .RESET_LEVEL (1'b1)
  ) countDirSyncInst (
    .clk     (clk),
    .resetn  (resetn),
    .asyncIn (countDirPinIn),
    .syncOut (countDirSync)
  );

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  assign modeHit              = (regAddr == `T2MC_MODE_ADDR);
  assign serialRxClockSelect  = timer2ModeReg_reg[`T2MC_RX_SEL_BIT];
  assign serialTxClockSelect  = timer2ModeReg_reg[`T2MC_TX_SEL_BIT];
  assign timerPinOutputEnable = timer2ModeReg_reg[`T2MC_PIN_OE_BIT];
  assign downCountEnable      = timer2ModeReg_reg[`T2MC_DOWN_EN_BIT];

  always_comb begin
    timer2ModeReg_next = timer2ModeReg_reg;
    regRdData_next     = 8'h00;
    if (regWr && modeHit) begin
      timer2ModeReg_next = regWrData & `T2MC_MODE_MASK;
    end
    if (regRd && modeHit) begin
      regRdData_next = timer2ModeReg_reg & `T2MC_MODE_MASK;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timer2ModeReg_reg <= `T2MC_MODE_RESET;
      regRdData_reg     <= 8'h00;
    end else begin
      timer2ModeReg_reg <= timer2ModeReg_next;
      regRdData_reg     <= regRdData_next;
    end
  end

  // ----------------------------------------------------------------
  // Baud clock source selection
  // ----------------------------------------------------------------
  always_comb begin
    rxBaudTick_next = serialRxClockSelect ? timer2Overflow : timer1Overflow;
    txBaudTick_next = serialTxClockSelect ? timer2Overflow : timer1Overflow;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxBaudTick_reg <= 1'b0;
      txBaudTick_reg <= 1'b0;
    end else begin
      rxBaudTick_reg <= rxBaudTick_next;
      txBaudTick_reg <= txBaudTick_next;
    end
  end

  // ----------------------------------------------------------------
  // Timer pin role, toggle output and counter input
  // ----------------------------------------------------------------
  // The pin role follows the enable bit; when the pin turns to output it
  // starts from the level it last held, so no glitch is forced on release.
  always_comb begin
    pinRole_next      = timerPinOutputEnable ? t2mc_pkg::T2MC_PIN_OUTPUT
                                             : t2mc_pkg::T2MC_PIN_INPUT;
    timerPinOut_next  = timerPinOut_reg;
    timerPinOe_n_next = 1'b1;
    counterTick_next  = 1'b0;
    pinLast_next      = timerPinSync;
    unique case (pinRole_reg)
      t2mc_pkg::T2MC_PIN_OUTPUT: begin
        timerPinOe_n_next = !timerPinOutputEnable;
        if (timer2Overflow) begin
          timerPinOut_next = !timerPinOut_reg;
        end
      end
      t2mc_pkg::T2MC_PIN_INPUT: begin
        timerPinOe_n_next = !timerPinOutputEnable;
        // A falling edge of the pin is one count event.
        counterTick_next  = !timerPinOutputEnable && counterMode &&
                            pinLast_reg && !timerPinSync;
      end
      default: begin
        timerPinOe_n_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinRole_reg      <= t2mc_pkg::T2MC_PIN_INPUT;
      timerPinOut_reg  <= 1'b1;
      timerPinOe_n_reg <= 1'b1;
      counterTick_reg  <= 1'b0;
      pinLast_reg      <= 1'b1;
    end else begin
      pinRole_reg      <= pinRole_next;
      timerPinOut_reg  <= timerPinOut_next;
      timerPinOe_n_reg <= timerPinOe_n_next;
      counterTick_reg  <= counterTick_next;
      pinLast_reg      <= pinLast_next;
    end
  end

  // ----------------------------------------------------------------
  // Count direction
  // ----------------------------------------------------------------
  always_comb begin
    countDir_next = t2mc_pkg::T2MC_COUNT_UP;
    if (autoReloadMode && downCountEnable) begin
      countDir_next = countDirSync ? t2mc_pkg::T2MC_COUNT_UP
                                   : t2mc_pkg::T2MC_COUNT_DOWN;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      countDir_reg <= t2mc_pkg::T2MC_COUNT_UP;
    end else begin
      countDir_reg <= countDir_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regRdData    = regRdData_reg;
  assign timerPinOut  = timerPinOut_reg;
  assign timerPinOe_n = timerPinOe_n_reg;
  assign rxBaudTick   = rxBaudTick_reg;
  assign txBaudTick   = txBaudTick_reg;
  assign counterTick  = counterTick_reg;
  assign countUp      = (countDir_reg == t2mc_pkg::T2MC_COUNT_UP);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  rx_source_select_a: assert property (
    ##1 (rxBaudTick == ($past(timer2ModeReg_reg[`T2MC_RX_SEL_BIT])
                        ? $past(timer2Overflow) : $past(timer1Overflow))))
    else $error("Receive baud tick does not follow the selected timer.");

  tx_source_select_a: assert property (
    (!timer2ModeReg_reg[`T2MC_TX_SEL_BIT] && timer1Overflow && !timer2Overflow)
      |=> txBaudTick)
    else $error("Transmit baud tick missing from the first timer.");

  pin_input_count_a: assert property (
    (!timer2ModeReg_reg[`T2MC_PIN_OE_BIT] && pinRole_reg == t2mc_pkg::T2MC_PIN_INPUT
      && counterMode && pinLast_reg && !timerPinSync) |=> counterTick)
    else $error("Pin fall in counter mode did not make a count pulse.");

  pin_input_release_a: assert property (
    $fell(timer2ModeReg_reg[`T2MC_PIN_OE_BIT]) |-> ##[1:2] timerPinOe_n)
    else $error("Timer pin still driven after output enable cleared.");

  pin_toggle_a: assert property (
    (pinRole_reg == t2mc_pkg::T2MC_PIN_OUTPUT && timer2Overflow)
      |=> (timerPinOut != $past(timerPinOut)))
    else $error("Timer pin did not invert on overflow.");

  pin_drive_a: assert property (
    $rose(timer2ModeReg_reg[`T2MC_PIN_OE_BIT]) |-> ##2 !timerPinOe_n)
    else $error("Timer pin not driven two cycles after output enable set.");

  up_only_a: assert property (
    (!timer2ModeReg_reg[`T2MC_DOWN_EN_BIT]) |=> countUp)
    else $error("Count direction not up with down-count disabled.");

  pin_direction_a: assert property (
    (autoReloadMode && timer2ModeReg_reg[`T2MC_DOWN_EN_BIT])
      |=> (countUp == $past(countDirSync)))
    else $error("Count direction does not follow the direction pin.");

  direction_pin_path_a: assert property (
    (autoReloadMode && timer2ModeReg_reg[`T2MC_DOWN_EN_BIT] && !countDirSync)[*2]
      |=> !countUp)
    else $error("Low direction pin did not count down.");

  unused_bits_a: assert property (
    ((timer2ModeReg_reg & ~`T2MC_MODE_MASK) == 8'h00) &&
    ((regRdData & ~`T2MC_MODE_MASK) == 8'h00))
    else $error("Unused mode bits are not zero.");

  read_back_a: assert property (
    (regRd && modeHit) |=> (regRdData == $past(timer2ModeReg_reg)))
    else $error("Read data do not show the mode register.");

  write_store_a: assert property (
    (regWr && modeHit) |=> (timer2ModeReg_reg == ($past(regWrData) & `T2MC_MODE_MASK)))
    else $error("Mode register write not stored with unused bits dropped.");

  toggle_cover_c: cover property (
    (pinRole_reg == t2mc_pkg::T2MC_PIN_OUTPUT && timer2Overflow) ##1 timer2Overflow[*1]);

  count_down_cover_c: cover property (
    autoReloadMode && downCountEnable ##2 !countUp);

  baud_timer2_cover_c: cover property (
    serialRxClockSelect && serialTxClockSelect && timer2Overflow ##1 rxBaudTick && txBaudTick);

  pin_count_cover_c: cover property (counterTick);

endmodule // t2mc_mode_control

//--- t2mc_regs.svh
// Register offsets, field positions, reset values and timing counts of the mode control block.
`ifndef T2MC_REGS_SVH
`define T2MC_REGS_SVH

`define T2MC_ADDR_W        12
`define T2MC_MODE_ADDR     12'h419
`define T2MC_MODE_RESET    8'h00
`define T2MC_MODE_MASK     8'h33
`define T2MC_RX_SEL_BIT    5
`define T2MC_TX_SEL_BIT    4
`define T2MC_PIN_OE_BIT    1
`define T2MC_DOWN_EN_BIT   0
`define T2MC_SYNC_STAGES   2

`endif

//--- t2mc_pkg.sv
// Types shared by the timer mode control block.
package t2mc_pkg;

  // Role of the timer pin, one-hot.
  typedef enum logic [1:0] {
    T2MC_PIN_INPUT  = 2'b01,
    T2MC_PIN_OUTPUT = 2'b10
  } t2mc_pin_role_t;

  // Count direction handed to the timer datapath.
  typedef enum logic {
    T2MC_COUNT_DOWN = 1'b0,
    T2MC_COUNT_UP   = 1'b1
  } t2mc_dir_t;

endpackage

//--- t2mc_sync.sv
// Two-flop synchroniser for one asynchronous pin level.
`timescale 1ns/1ns
module t2mc_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic clk,      // System clock.
  input  wire logic resetn,   // Asynchronous reset, active low.
  input  wire logic asyncIn,  // Level from outside the clock domain.
  output logic      syncOut   // Level safe to use in the clock domain.
);

  logic stage1_reg;
  logic stage1_next;
  logic stage2_reg;
  logic stage2_next;

  always_comb begin
    stage1_next = asyncIn;
    stage2_next = stage1_reg;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1_reg <= RESET_LEVEL;
      stage2_reg <= RESET_LEVEL;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign syncOut = stage2_reg;

endmodule // t2mc_sync

//--- t2mc_mode_control_test.sv
// Self-checking testbench of the timer mode control block.
`timescale 1ns/1ns
`include "t2mc_regs.svh"
module t2mc_mode_control_test;
  // ----------------------------------------------------------------
  // Signals and design instance
  // ----------------------------------------------------------------
  logic                    clk;
  logic                    resetn;
  logic [`T2MC_ADDR_W-1:0] regAddr;
  logic [7:0]              regWrData;
  logic                    regWr;
  logic                    regRd;
  logic [7:0]              regRdData;
  logic                    timer1Overflow;
  logic                    timer2Overflow;
  logic                    counterMode;
  logic                    autoReloadMode;
  logic                    timerPinIn;
  logic                    countDirPinIn;
  logic                    timerPinOut;
  logic                    timerPinOe_n;
  logic                    rxBaudTick;
  logic                    txBaudTick;
  logic                    counterTick;
  logic                    countUp;
  int                      numErrors;
  int                      numChecks;

  t2mc_mode_control uut (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .timer1Overflow(timer1Overflow), .timer2Overflow(timer2Overflow),
    .counterMode(counterMode), .autoReloadMode(autoReloadMode),
    .timerPinIn(timerPinIn), .countDirPinIn(countDirPinIn),
    .timerPinOut(timerPinOut), .timerPinOe_n(timerPinOe_n),
    .rxBaudTick(rxBaudTick), .txBaudTick(txBaudTick),
    .counterTick(counterTick), .countUp(countUp)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    numChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic regWrite(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, then return to zero.
  task automatic regRead(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    check(regRdData, exp, "read data");
    @(posedge clk);
    #1;
    check(regRdData, 8'h00, "read data after its cycle");
  endtask

  task automatic pulse(input logic t1, input logic t2, input logic expRx, input logic expTx);
    @(posedge clk);
    timer1Overflow <= t1;
    timer2Overflow <= t2;
    @(posedge clk);
    timer1Overflow <= 1'b0;
    timer2Overflow <= 1'b0;
    #1;
    check(rxBaudTick, expRx, "receive tick");
    check(txBaudTick, expTx, "transmit tick");
  endtask

  task automatic waitCycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic countTicks(output int n);
    n = 0;
    repeat (6) begin
      @(posedge clk);
      #1;
      if (counterTick === 1'b1) n++;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic testRegister;
    regRead(`T2MC_MODE_ADDR, `T2MC_MODE_RESET);
    regWrite(`T2MC_MODE_ADDR, 8'hff);
    regRead(`T2MC_MODE_ADDR, 8'h33);
    regWrite(12'h418, 8'h00);
    regRead(`T2MC_MODE_ADDR, 8'h33);
    regRead(12'h418, 8'h00);
    regWrite(`T2MC_MODE_ADDR, 8'hcc);
    regRead(`T2MC_MODE_ADDR, 8'h00);
    $display("test register done");
  endtask

  task automatic testBaud;
    logic [1:0] sel;
    for (int i = 0; i < 4; i++) begin
      sel = i[1:0];
      regWrite(`T2MC_MODE_ADDR, {2'b00, sel, 4'h0});
      pulse(1'b0, 1'b1, sel[1], sel[0]);
      pulse(1'b1, 1'b0, ~sel[1], ~sel[0]);
      pulse(1'b1, 1'b1, 1'b1, 1'b1);
    end
    $display("test baud done");
  endtask

  task automatic testPin;
    int n;
    regWrite(`T2MC_MODE_ADDR, 8'h02);
    waitCycles(2);
    check(timerPinOe_n, 1'b0, "pin driven");
    check(timerPinOut, 1'b1, "pin level");
    pulse(1'b0, 1'b1, 1'b0, 1'b0);
    check(timerPinOut, 1'b0, "pin toggled");
    pulse(1'b0, 1'b1, 1'b0, 1'b0);
    check(timerPinOut, 1'b1, "pin toggled");
    @(posedge clk);
    counterMode <= 1'b1;
    timerPinIn <= 1'b0;
    countTicks(n);
    check(n[7:0], 8'h00, "tick with pin as output");
    @(posedge clk);
    timerPinIn <= 1'b1;
    waitCycles(4);
    regWrite(`T2MC_MODE_ADDR, 8'h00);
    waitCycles(2);
    check(timerPinOe_n, 1'b1, "pin released");
    pulse(1'b0, 1'b1, 1'b0, 1'b0);
    check(timerPinOut, 1'b1, "pin not toggled");
    @(posedge clk);
    timerPinIn <= 1'b0;
    countTicks(n);
    check(n[7:0], 8'h01, "tick from pin fall");
    @(posedge clk);
    counterMode <= 1'b0;
    timerPinIn <= 1'b1;
    waitCycles(4);
    @(posedge clk);
    timerPinIn <= 1'b0;
    countTicks(n);
    check(n[7:0], 8'h00, "tick outside counter mode");
    $display("test pin done");
  endtask

  task automatic testDirection;
    @(posedge clk);
    autoReloadMode <= 1'b1;
    countDirPinIn <= 1'b0;
    regWrite(`T2MC_MODE_ADDR, 8'h00);
    waitCycles(4);
    check(countUp, 1'b1, "up only");
    regWrite(`T2MC_MODE_ADDR, 8'h01);
    waitCycles(1);
    check(countUp, 1'b0, "down from pin");
    @(posedge clk);
    countDirPinIn <= 1'b1;
    waitCycles(4);
    check(countUp, 1'b1, "up from pin");
    @(posedge clk);
    countDirPinIn <= 1'b0;
    waitCycles(4);
    check(countUp, 1'b0, "down from pin");
    @(posedge clk);
    autoReloadMode <= 1'b0;
    waitCycles(2);
    check(countUp, 1'b1, "up outside auto-reload");
    $display("test direction done");
  endtask

  // A reset in mid-run must drop the pin drive and the down count at once.
  task automatic testReset;
    @(posedge clk);
    autoReloadMode <= 1'b1;
    countDirPinIn <= 1'b0;
    regWrite(`T2MC_MODE_ADDR, 8'h33);
    waitCycles(4);
    check(timerPinOe_n, 1'b0, "pin driven before reset");
    check(countUp, 1'b0, "down before reset");
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    #1;
    check(timerPinOe_n, 1'b1, "pin released in reset");
    check(countUp, 1'b1, "up in reset");
    @(posedge clk);
    resetn <= 1'b1;
    regRead(`T2MC_MODE_ADDR, `T2MC_MODE_RESET);
    check(countUp, 1'b1, "up after reset");
    $display("test reset done");
  endtask

  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic printVerdict;
    $display("checks %0d mismatches %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    numErrors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    printVerdict();
  end

  initial begin
    numErrors = 0;
    numChecks = 0;
    resetn = 1'b0;
    regAddr = '0;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    timer1Overflow = 1'b0;
    timer2Overflow = 1'b0;
    counterMode = 1'b0;
    autoReloadMode = 1'b0;
    timerPinIn = 1'b1;
    countDirPinIn = 1'b1;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    testRegister();
    testBaud();
    testPin();
    testDirection();
    testReset();
    printVerdict();
  end
endmodule  // t2mc_mode_control_test
